// File: logic/eic_top.sv
// How it works
// - Sixteen DC inputs form eight pairs, each pair with its own filter time.
// - Input level is recognised only after holding for the selected filter time.
// - Four 12-bit analog values go to image words four to seven in order.
// - Analog update waits one scan plus the selected settling time.
// - Analog filter setting resets to the 10 Hz option.
// - Analog code is volts times 4095 over ten, unsigned.
// - Analog outputs take their values from output words four and five.
// - Analog output level is ten volts times word over 4095.
// - Inputs zero to eleven each have an individual latching enable.
// - Each latching input picks rising or falling capture.
// - Captured edge flips image bit from its rest level at next scan, for exactly one scan.
// - Pulses must pass the input filter before they can latch.
// - Latched inputs show the latch, not the pin; rising mode rests off.
// - Falling mode rests on and goes off for one scan.
`timescale 1ns/1ps
module eic_top
   import eic_pkg::*;
#(
   parameter int N_DIN = NUM_DIN,
   parameter int N_LATCH = NUM_LATCH,
   parameter int AS_10HZ = AS_CNT_10HZ,
   parameter int AS_50HZ = AS_CNT_50HZ,
   parameter int AS_60HZ = AS_CNT_60HZ,
   parameter int AS_250HZ = AS_CNT_250HZ
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [N_DIN-1:0] din_pins,
   input wire logic [N_DIN/2*FSEL_W-1:0] group_filter_sel,
   input wire logic [N_LATCH-1:0] latch_enable,
   input wire logic [N_LATCH-1:0] latch_falling,
   input wire logic input_scan,
   output logic [N_DIN-1:0] din_image,
   input wire logic [AWIDTH-1:0] ain_code_0,
   input wire logic [AWIDTH-1:0] ain_code_1,
   input wire logic [AWIDTH-1:0] ain_code_2,
   input wire logic [AWIDTH-1:0] ain_code_3,
   input wire logic [ASEL_W-1:0] ain_filter_sel,
   input wire logic ain_filter_load,
   output logic [ASEL_W-1:0] ain_filter_now,
   output logic [AWIDTH-1:0] ain_word_4,
   output logic [AWIDTH-1:0] ain_word_5,
   output logic [AWIDTH-1:0] ain_word_6,
   output logic [AWIDTH-1:0] ain_word_7,
   output logic ain_update,
   input wire logic [AWIDTH-1:0] aout_word_4,
   input wire logic [AWIDTH-1:0] aout_word_5,
   input wire logic aout_load,
   output logic [AWIDTH-1:0] aout_dac_0,
   output logic [AWIDTH-1:0] aout_dac_1
);
   // ------------------------------------------------------------
   // Parameter checks
   // ------------------------------------------------------------
   initial begin
      if (N_DIN != NUM_DIN) $error("eic_top: DC input count must be 16");
      if (N_DIN % 2 != 0) $error("eic_top: inputs must come in pairs");
      if (N_LATCH < 1) $error("eic_top: at least one latching input needed");
      if (N_LATCH > N_DIN) $error("eic_top: more latching inputs than inputs");
      // A zero settle count would wrap the end-of-window compare
      if (AS_10HZ < 1 || AS_50HZ < 1 || AS_60HZ < 1 || AS_250HZ < 1) begin
         $error("eic_top: settling counts must be positive");
      end
      if (AS_10HZ >= (1 << AS_CNT_W)) $error("eic_top: settling count too wide");
      if (AS_50HZ >= (1 << AS_CNT_W) || AS_60HZ >= (1 << AS_CNT_W)) begin
         $error("eic_top: settling count too wide");
      end
      if (AS_250HZ >= (1 << AS_CNT_W)) $error("eic_top: settling count too wide");
      if (DF_TIME_US_7 * (CLK_HZ / 1000000) >= (1 << DF_CNT_W)) begin
         $error("eic_top: filter count too wide");
      end
   end

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [N_DIN-1:0] sync1_reg, sync2_reg;
   logic [N_DIN-1:0] sync1_next, sync2_next;
   logic [N_DIN-1:0] filtered;

   // Only the second stage feeds logic; the first may be metastable
   always_comb begin
      sync1_next = din_pins;
      sync2_next = sync1_reg;
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
      end
   end

   // ------------------------------------------------------------
   // Filter time per code
   // ------------------------------------------------------------
   function automatic logic [DF_CNT_W-1:0] df_limit(input logic [FSEL_W-1:0] sel);
      int us;
      us = 0;
      case (sel)
         3'h0: us = DF_TIME_US_0;
         3'h1: us = DF_TIME_US_1;
         3'h2: us = DF_TIME_US_2;
         3'h3: us = DF_TIME_US_3;
         3'h4: us = DF_TIME_US_4;
         3'h5: us = DF_TIME_US_5;
         3'h6: us = DF_TIME_US_6;
         3'h7: us = DF_TIME_US_7;
         default: us = DF_TIME_US_0;
      endcase
      // Count of cycles already spent stable; zero still means one cycle
      df_limit = DF_CNT_W'(us * (CLK_HZ / 1000000));
   endfunction

   // ------------------------------------------------------------
   // Per-input filter and latch
   // ------------------------------------------------------------
   // One decoder per pair rather than per input
   logic [DF_CNT_W-1:0] pair_limit [N_DIN/2];

   genvar gp;
   generate
      for (gp = 0; gp < N_DIN / 2; gp++) begin : g_pair
         assign pair_limit[gp] = df_limit(group_filter_sel[gp*FSEL_W +: FSEL_W]);
      end
   endgenerate

   genvar gi;
   generate
      for (gi = 0; gi < N_DIN; gi++) begin : g_din
         logic [DF_CNT_W-1:0] lim;
         // Both inputs of a pair share one setting
         assign lim = pair_limit[gi/2];

         eic_debounce #(.CNT_W(DF_CNT_W)) u_deb (
            .clock(clock),
            .reset(reset),
            .raw(sync2_reg[gi]),
            .limit(lim),
            .state(filtered[gi])
         );

         if (gi < N_LATCH) begin : g_latch
            eic_pulse_catch u_pc (
               .clock(clock),
               .reset(reset),
               .filtered(filtered[gi]),
               .enable(latch_enable[gi]),
               .falling(latch_falling[gi]),
               .scan(input_scan),
               .image(din_image[gi])
            );
         end else begin : g_plain
            logic img_reg, img_next;
            always_comb begin
               img_next = input_scan ? filtered[gi] : img_reg;
            end
            always_ff @(posedge clock) begin
               if (reset) begin
                  img_reg <= 1'b0;
               end else begin
                  img_reg <= img_next;
               end
            end
            assign din_image[gi] = img_reg;
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Analog input settling and update
   // ------------------------------------------------------------
   // Scans that arrive while settling are ignored, not queued
   typedef enum logic [1:0] {EIC_AI_WAIT_SCAN, EIC_AI_SETTLE, EIC_AI_PUBLISH} eic_ai_state_t;

   eic_ai_state_t ai_state_reg, ai_state_next;
   eic_afilt_t afilt_reg, afilt_next;
   logic [AS_CNT_W-1:0] settle_reg, settle_next;
   logic [AS_CNT_W-1:0] settle_limit;
   logic settle_done;
   logic [AWIDTH-1:0] aw_reg [NUM_AIN];
   logic [AWIDTH-1:0] aw_next [NUM_AIN];
   logic [AWIDTH-1:0] ain_in [NUM_AIN];
   logic upd_reg, upd_next;

   assign ain_in[0] = ain_code_0;
   assign ain_in[1] = ain_code_1;
   assign ain_in[2] = ain_code_2;
   assign ain_in[3] = ain_code_3;

   always_comb begin
      case (afilt_reg)
         EIC_AF_10HZ: settle_limit = AS_CNT_W'(AS_10HZ);
         EIC_AF_50HZ: settle_limit = AS_CNT_W'(AS_50HZ);
         EIC_AF_60HZ: settle_limit = AS_CNT_W'(AS_60HZ);
         EIC_AF_250HZ: settle_limit = AS_CNT_W'(AS_250HZ);
         default: settle_limit = AS_CNT_W'(AS_10HZ);
      endcase
   end

   assign settle_done = (settle_reg >= settle_limit - 1'b1);

   always_comb begin
      ai_state_next = ai_state_reg;
      afilt_next = afilt_reg;
      settle_next = settle_reg;
      upd_next = 1'b0;
      for (int i = 0; i < NUM_AIN; i++) begin
         aw_next[i] = aw_reg[i];
      end
      // A new setting cancels settling; it restarts at the next scan
      if (ain_filter_load) begin
         afilt_next = eic_afilt_t'(ain_filter_sel);
         ai_state_next = EIC_AI_WAIT_SCAN;
         settle_next = '0;
      end else begin
         case (ai_state_reg)
            EIC_AI_WAIT_SCAN: begin
               settle_next = '0;
               if (input_scan) begin
                  ai_state_next = EIC_AI_SETTLE;
               end
            end
            EIC_AI_SETTLE: begin
               if (settle_done) begin
                  ai_state_next = EIC_AI_PUBLISH;
               end else begin
                  settle_next = settle_reg + 1'b1;
               end
            end
            EIC_AI_PUBLISH: begin
               // Converter code already equals volts times 4095 over ten
               for (int i = 0; i < NUM_AIN; i++) begin
                  aw_next[i] = ain_in[i];
               end
               upd_next = 1'b1;
               ai_state_next = EIC_AI_WAIT_SCAN;
            end
            default: ai_state_next = EIC_AI_WAIT_SCAN;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         ai_state_reg <= EIC_AI_WAIT_SCAN;
         afilt_reg <= AFILT_RESET;
         settle_reg <= '0;
         upd_reg <= 1'b0;
         for (int i = 0; i < NUM_AIN; i++) begin
            aw_reg[i] <= '0;
         end
      end else begin
         ai_state_reg <= ai_state_next;
         afilt_reg <= afilt_next;
         settle_reg <= settle_next;
         upd_reg <= upd_next;
         for (int i = 0; i < NUM_AIN; i++) begin
            aw_reg[i] <= aw_next[i];
         end
      end
   end

   assign ain_word_4 = aw_reg[0];
   assign ain_word_5 = aw_reg[1];
   assign ain_word_6 = aw_reg[2];
   assign ain_word_7 = aw_reg[3];
   assign ain_update = upd_reg;
   assign ain_filter_now = afilt_reg;

   // ------------------------------------------------------------
   // Analog outputs
   // ------------------------------------------------------------
   // Word drives the converter directly; full scale 4095 is ten volts
   logic [AWIDTH-1:0] aout_in [NUM_AOUT];
   logic [AWIDTH-1:0] dac_q [NUM_AOUT];

   assign aout_in[0] = aout_word_4;
   assign aout_in[1] = aout_word_5;

   genvar go;
   generate
      for (go = 0; go < NUM_AOUT; go++) begin : g_aout
         logic [AWIDTH-1:0] dac_reg, dac_next;
         always_comb begin
            dac_next = aout_load ? aout_in[go] : dac_reg;
         end
         always_ff @(posedge clock) begin
            if (reset) begin
               dac_reg <= '0;
            end else begin
               dac_reg <= dac_next;
            end
         end
         assign dac_q[go] = dac_reg;
      end
   endgenerate

   assign aout_dac_0 = dac_q[0];
   assign aout_dac_1 = dac_q[1];
endmodule

// File: logic/eic_pkg.sv
package eic_pkg;
   // ------------------------------------------------------------
   // Clock and sizes
   // ------------------------------------------------------------
   localparam int CLK_HZ = 25000000;
   localparam int NUM_DIN = 16;
   localparam int NUM_GROUPS = NUM_DIN / 2;
   localparam int NUM_LATCH = 12;
   localparam int NUM_AIN = 4;
   localparam int NUM_AOUT = 2;
   localparam int AWIDTH = 12;
   localparam int FSEL_W = 3;
   localparam int ASEL_W = 2;
   localparam int AIN_FIRST_WORD = 4;
   localparam int AOUT_FIRST_WORD = 4;
   localparam logic [AWIDTH-1:0] FULL_SCALE = 12'hfff;
   localparam int FULL_SCALE_MV = 10000;

   // ------------------------------------------------------------
   // Discrete filter times in microseconds, per setting code
   // ------------------------------------------------------------
   localparam int DF_TIME_US_0 = 0;
   localparam int DF_TIME_US_1 = 100;
   localparam int DF_TIME_US_2 = 500;
   localparam int DF_TIME_US_3 = 1000;
   localparam int DF_TIME_US_4 = 2000;
   localparam int DF_TIME_US_5 = 4000;
   localparam int DF_TIME_US_6 = 8000;
   localparam int DF_TIME_US_7 = 16000;
   localparam int DF_CNT_W = 20;

   // ------------------------------------------------------------
   // Analog settling times in microseconds
   // ------------------------------------------------------------
   localparam int AS_TIME_US_10HZ = 100000;
   localparam int AS_TIME_US_50HZ = 20000;
   localparam int AS_TIME_US_60HZ = 16670;
   localparam int AS_TIME_US_250HZ = 4000;
   localparam int AS_CNT_10HZ = AS_TIME_US_10HZ * (CLK_HZ / 1000000);
   localparam int AS_CNT_50HZ = AS_TIME_US_50HZ * (CLK_HZ / 1000000);
   localparam int AS_CNT_60HZ = AS_TIME_US_60HZ * (CLK_HZ / 1000000);
   localparam int AS_CNT_250HZ = AS_TIME_US_250HZ * (CLK_HZ / 1000000);
   localparam int AS_CNT_W = 22;

   typedef enum logic [ASEL_W-1:0] {
      EIC_AF_10HZ,
      EIC_AF_50HZ,
      EIC_AF_60HZ,
      EIC_AF_250HZ
   } eic_afilt_t;

   localparam eic_afilt_t AFILT_RESET = EIC_AF_10HZ;
   localparam logic LATCH_EN_RESET = 1'b0;
   localparam logic LATCH_FALL_RESET = 1'b0;
endpackage

// File: logic/eic_debounce.sv
`timescale 1ns/1ps
module eic_debounce
   import eic_pkg::*;
#(
   parameter int CNT_W = DF_CNT_W
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic raw,
   input wire logic [CNT_W-1:0] limit,
   output logic state
);
   // ------------------------------------------------------------
   // Stability counter
   // ------------------------------------------------------------
   logic state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;

   initial begin
      if (CNT_W < 1) $error("eic_debounce: CNT_W too small");
   end

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      if (raw == state_reg) begin
         cnt_next = '0;
      end else if (cnt_reg >= limit) begin
         state_next = raw;
         cnt_next = '0;
      end else begin
         cnt_next = cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state_reg <= 1'b0;
         cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   assign state = state_reg;
endmodule

// File: logic/eic_pulse_catch.sv
`timescale 1ns/1ps
module eic_pulse_catch
   import eic_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic filtered,
   input wire logic enable,
   input wire logic falling,
   input wire logic scan,
   output logic image
);
   // ------------------------------------------------------------
   // Edge capture and one-scan presentation
   // ------------------------------------------------------------
   logic prev_reg, prev_next;
   logic caught_reg, caught_next;
   logic image_reg, image_next;
   logic edge_hit;

   // Edge is taken from the filtered level, so narrow pulses never latch
   assign edge_hit = falling ? (prev_reg & ~filtered)
                             : (~prev_reg & filtered);

   always_comb begin
      prev_next = filtered;
      caught_next = caught_reg;
      image_next = image_reg;
      if (!enable) begin
         caught_next = 1'b0;
         if (scan) begin
            image_next = filtered;
         end
      end else begin
         if (scan) begin
            caught_next = 1'b0;
            image_next = caught_reg ^ falling;
         end
         // A capture in a scan cycle is kept for the next scan
         if (edge_hit) begin
            caught_next = 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         prev_reg <= 1'b0;
         caught_reg <= 1'b0;
         image_reg <= 1'b0;
      end else begin
         prev_reg <= prev_next;
         caught_reg <= caught_next;
         image_reg <= image_next;
      end
   end

   assign image = image_reg;
endmodule

// File: test/eic_checker.sv
`timescale 1ns/1ps
module eic_checker
   import eic_pkg::*;
#(
   parameter int N_DIN = NUM_DIN
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic input_scan,
   input wire logic [N_DIN-1:0] din_image,
   input wire logic [ASEL_W-1:0] ain_filter_sel,
   input wire logic ain_filter_load,
   input wire logic [ASEL_W-1:0] ain_filter_now,
   input wire logic [AWIDTH-1:0] ain_word_4,
   input wire logic [AWIDTH-1:0] ain_word_7,
   input wire logic ain_update,
   input wire logic [AWIDTH-1:0] aout_word_4,
   input wire logic [AWIDTH-1:0] aout_word_5,
   input wire logic aout_load,
   input wire logic [AWIDTH-1:0] aout_dac_0,
   input wire logic [AWIDTH-1:0] aout_dac_1
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   // ------------------------------------------------------------
   // Named steps
   // ------------------------------------------------------------
   // Shortest settling is four cycles, so a publish is never followed soon
   sequence s_publish;
      ain_update ##1 !ain_update [*4];
   endsequence
   sequence s_dac_take;
      aout_dac_0 == $past(aout_word_4) && aout_dac_1 == $past(aout_word_5);
   endsequence
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_image_on_scan: assert property ($changed(din_image) |-> $past(input_scan) || $past(reset))
      else $error("image changed without a scan");
   a_dac_load_take: assert property (aout_load |=> s_dac_take)
      else $error("dac codes not taken from output words");
   a_dac_hold_idle: assert property (!aout_load |=> $stable(aout_dac_0) && $stable(aout_dac_1))
      else $error("dac code moved without a load");
   a_ain_words_pub: assert property ($changed(ain_word_4) || $changed(ain_word_7) |-> ain_update || $past(reset))
      else $error("analog words changed without update");
   a_ain_update_gap: assert property (ain_update |-> s_publish)
      else $error("analog update came too soon");
   a_filter_default: assert property ($fell(reset) |-> ain_filter_now == EIC_AF_10HZ)
      else $error("analog filter not at default after reset");
   a_filter_load_take: assert property (ain_filter_load |=> ain_filter_now == $past(ain_filter_sel))
      else $error("analog filter setting not loaded");
   a_filter_hold_idle: assert property (!ain_filter_load |=> $stable(ain_filter_now))
      else $error("analog filter setting moved without load");
endmodule

// File: test/eic_field.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Field side: switches and transducers with converter
// ------------------------------------------------------------
module eic_field
   import eic_pkg::*;
(
   input wire logic clock,
   output logic [NUM_DIN-1:0] din_pins,
   output logic [AWIDTH-1:0] ain_code [NUM_AIN]
);
   initial begin
      din_pins = '0;
      foreach (ain_code[i]) ain_code[i] = '0;
   end
   task automatic set_pins(input logic [NUM_DIN-1:0] mask, input logic lvl);
      @(negedge clock);
      din_pins = lvl ? (din_pins | mask) : (din_pins & ~mask);
   endtask
   // Truncating divide, as a real converter rounds down
   task automatic set_mv(input int ch, input int mv);
      @(negedge clock);
      ain_code[ch] = AWIDTH'(mv * 4095 / FULL_SCALE_MV);
   endtask
endmodule

// File: test/embedded_input_conditioning_test.sv
`timescale 1ns/1ps
module embedded_input_conditioning_test;
   import eic_pkg::*;
   // Starts low by declaration so time zero gives no false falling edge
   logic clock = 1'b0;
   logic reset, input_scan, ain_filter_load, aout_load, ain_update;
   logic [15:0] din_image;
   wire logic [15:0] din_pins;
   wire logic [11:0] ain_code [4];
   logic [23:0] group_filter_sel;
   logic [11:0] latch_enable, latch_falling, aout_word_4, aout_word_5, aout_dac_0, aout_dac_1;
   logic [1:0] ain_filter_sel, ain_filter_now;
   logic [11:0] ain_word [4];
   int errors, checked, cycles, n;
   int st [4] = '{20, 10, 8, 4};
   // ------------------------------------------------------------
   // Clock, partner, design
   // ------------------------------------------------------------
   initial begin
      forever #20 clock = ~clock;
   end
   eic_field field (.clock(clock), .din_pins(din_pins), .ain_code(ain_code));
   eic_top #(.AS_10HZ(20), .AS_50HZ(10), .AS_60HZ(8), .AS_250HZ(4)) dut (
      .clock(clock), .reset(reset), .din_pins(din_pins), .group_filter_sel(group_filter_sel),
      .latch_enable(latch_enable), .latch_falling(latch_falling), .input_scan(input_scan),
      .din_image(din_image), .ain_code_0(ain_code[0]), .ain_code_1(ain_code[1]),
      .ain_code_2(ain_code[2]), .ain_code_3(ain_code[3]), .ain_filter_sel(ain_filter_sel),
      .ain_filter_load(ain_filter_load), .ain_filter_now(ain_filter_now),
      .ain_word_4(ain_word[0]), .ain_word_5(ain_word[1]), .ain_word_6(ain_word[2]),
      .ain_word_7(ain_word[3]), .ain_update(ain_update), .aout_word_4(aout_word_4),
      .aout_word_5(aout_word_5), .aout_load(aout_load), .aout_dac_0(aout_dac_0),
      .aout_dac_1(aout_dac_1));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic end_sim;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Image lands on the same edge that takes the scan
   task automatic scan;
      @(negedge clock) input_scan = 1;
      @(negedge clock) input_scan = 0;
      @(negedge clock);
   endtask
   task automatic idle(input int k);
      repeat (k) @(negedge clock);
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 25000) begin
         errors++;
         end_sim();
      end
   end
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      reset = 1;
      input_scan = 0;
      ain_filter_load = 0;
      ain_filter_sel = 2'h0;
      aout_load = 0;
      aout_word_4 = 12'h000;
      aout_word_5 = 12'h000;
      group_filter_sel = 24'h400001;
      latch_enable = 12'h032;
      latch_falling = 12'h020;
      idle(8);
      reset = 0;
      @(negedge clock);
      check("ain_filter_now", 16'h0000, ain_filter_now);
      check("din_image", 16'h0000, din_image);
      // Back-to-back loads, then word four moves with no load
      aout_word_4 = 12'h800;
      aout_word_5 = 12'hfff;
      aout_load = 1;
      @(negedge clock);
      check("aout_dac_0", 16'h0800, aout_dac_0);
      check("aout_dac_1", 16'h0fff, aout_dac_1);
      aout_word_4 = 12'hbb8;
      aout_word_5 = 12'h001;
      @(negedge clock) aout_load = 0;
      aout_word_4 = 12'h123;
      idle(2);
      check("aout_dac_0", 16'h0bb8, aout_dac_0);
      check("aout_dac_1", 16'h0001, aout_dac_1);
      // Every analog filter setting, settle counted from the scan
      for (int k = 0; k < 4; k++) begin
         for (int c = 0; c < 4; c++) field.set_mv(c, 1000 * k + 2000 * c + 300);
         @(negedge clock) ain_filter_sel = k[1:0];
         ain_filter_load = 1;
         @(negedge clock) ain_filter_load = 0;
         check("ain_filter_now", 16'(k), ain_filter_now);
         input_scan = 1;
         @(negedge clock) input_scan = 0;
         n = 0;
         while (ain_update !== 1'b1 && n < 200) begin
            @(negedge clock);
            n++;
         end
         check("ain_settle_ok", 16'h1, 16'(n >= st[k] + 1 && n <= st[k] + 2));
         for (int c = 0; c < 4; c++) begin
            check("ain_word", 16'((1000 * k + 2000 * c + 300) * 4095 / 10000), ain_word[c]);
         end
      end
      // Falling latch rests on after its first scan
      scan();
      check("din_image", 16'h0020, din_image);
      // Pair 0 slow, pair 1 fast; glitch shorter than the slow filter
      field.set_pins(16'h0007, 1);
      idle(1000);
      field.set_pins(16'h0003, 0);
      idle(10);
      scan();
      check("din_image", 16'h0024, din_image);
      field.set_pins(16'h0003, 1);
      // Glitch restarted the count, so not yet recognised
      idle(2000);
      scan();
      check("din_image", 16'h0024, din_image);
      idle(600);
      scan();
      check("din_image", 16'h0027, din_image);
      scan();
      check("din_image", 16'h0025, din_image);
      // Short pulse on rising latch; rising edge ignored by falling latch
      field.set_pins(16'h0030, 1);
      idle(10);
      field.set_pins(16'h0010, 0);
      idle(10);
      scan();
      check("din_image", 16'h0035, din_image);
      field.set_pins(16'h0020, 0);
      idle(10);
      scan();
      check("din_image", 16'h0005, din_image);
      scan();
      check("din_image", 16'h0025, din_image);
      // Plain inputs: pair 6 fast, pair 7 at filter code 2
      field.set_pins(16'h5000, 1);
      idle(10);
      scan();
      check("din_image", 16'h1025, din_image);
      idle(12300);
      scan();
      check("din_image", 16'h1025, din_image);
      idle(300);
      scan();
      check("din_image", 16'h5025, din_image);
      end_sim();
   end
endmodule

bind eic_top eic_checker #(.N_DIN(N_DIN)) chk (
   .clock(clock), .reset(reset), .input_scan(input_scan), .din_image(din_image),
   .ain_filter_sel(ain_filter_sel), .ain_filter_load(ain_filter_load),
   .ain_filter_now(ain_filter_now), .ain_word_4(ain_word_4), .ain_word_7(ain_word_7),
   .ain_update(ain_update), .aout_word_4(aout_word_4), .aout_word_5(aout_word_5),
   .aout_load(aout_load), .aout_dac_0(aout_dac_0), .aout_dac_1(aout_dac_1));
